// >>> design/ptp_div.sv
`timescale 1ns/1ns
module ptp_div (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [31:0] num,
   input wire logic [6:0] den,
   output logic [31:0] quot,
   output logic rem_nz,
   output logic done
);
   logic [31:0] rem_r;
   // Division by repeated subtraction of the divisor, one per cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rem_r <= 32'h0;
         quot <= 32'h0;
         done <= 1'b0;
      end else if (start) begin
         rem_r <= num;
         quot <= 32'h0;
         done <= 1'b0;
      end else if (!done) begin
         if (rem_r >= {25'h0, den}) begin
            rem_r <= rem_r - {25'h0, den};
            quot <= quot + 32'h1;
         end else begin
            done <= 1'b1;
         end
      end
   end
   assign rem_nz = (rem_r != 32'h0);
endmodule

// >>> design/ptp_pkg.sv
package ptp_pkg;
   localparam int NCH = 4;
   localparam int TBL_WORDS = 6;
   // Clock and millisecond timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam logic [31:0] CLK_HZ = 32'd100000000;
   // Phase accumulator runs in half-hertz units
   localparam logic [31:0] PHASE_MOD = 32'd200000000;
   // Register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_START = 12'h004;
   localparam logic [11:0] OFF_BUSY = 12'h008;
   localparam logic [11:0] OFF_IMAGE = 12'h00C;
   localparam logic [11:0] OFF_MON = 12'h010;
   localparam logic [11:0] OFF_AREA = 12'h040;
   localparam logic [11:0] AREA_STRIDE = 12'h010;
   localparam logic [11:0] OFF_TBL = 12'h100;
   localparam logic [11:0] TBL_STRIDE = 12'h020;
   localparam logic [1:0] AW_ELAP_LO = 2'h0;
   localparam logic [1:0] AW_ELAP_HI = 2'h1;
   localparam logic [1:0] AW_TGT_LO = 2'h2;
   localparam logic [1:0] AW_TGT_HI = 2'h3;
   // Control write fields
   localparam int CB_RESET = 0;
   localparam int CB_STOP = 3;
   localparam int CB_NEAR = 4;
   localparam int CTRL_CH_LSB = 8;
   // Table entries
   localparam int TB_CODE = 0;
   localparam int TB_F0 = 1;
   localparam int TB_FMAX = 2;
   localparam int TB_RAMP = 3;
   localparam int TB_TARGET = 4;
   // Control code fields
   localparam int CC_STEP_LSB = 16;
   localparam int CC_DUTY_LSB = 12;
   localparam int CC_RANGE_LSB = 8;
   localparam logic [3:0] MODE_ABS = 4'h1;
   localparam logic [3:0] OUT_CWCCW = 4'h0;
   localparam logic [3:0] OUT_DIR_FWD_OFF = 4'h2;
   localparam logic [3:0] OUT_DIR_FWD_ON = 4'h3;
   localparam logic [6:0] STEPS_30 = 7'd30;
   localparam logic [6:0] STEPS_60 = 7'd60;
   // Frequency bands in Hz
   localparam logic [16:0] R0_MIN = 17'd1;
   localparam logic [16:0] R0_MAX = 17'd9800;
   localparam logic [16:0] R1_MIN = 17'd48;
   localparam logic [16:0] R2_MIN = 17'd191;
   localparam logic [16:0] R12_MAX = 17'd100000;
   localparam logic [17:0] INC_1P5HZ = 18'd3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CALC = 3'b010,
      ST_RUN = 3'b100
   } ptp_state_t;
   typedef enum logic [1:0] {
      PH_ACCEL = 2'b01,
      PH_CRUISE = 2'b10,
      PH_DECEL = 2'b11
   } ptp_phase_t;
   typedef struct packed {
      logic [3:0] fwd;
      logic [3:0] rev;
      logic [3:0] near_home;
   } ptp_pins_t;
endpackage

// >>> design/ptp_rate.sv
`timescale 1ns/1ns
module ptp_rate (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic en,
   input wire logic [17:0] inc,
   input wire logic quarter,
   output logic level,
   output logic rise
);
   import ptp_pkg::*;
   logic [31:0] acc_r;
   logic [31:0] sum;
   assign sum = acc_r + {14'h0, inc};
   // First wrap comes in the same cycle as enable
   assign rise = en && (sum >= PHASE_MOD);
   assign level = en && (acc_r < (quarter ? (PHASE_MOD >> 2) : (PHASE_MOD >> 1)));
   always_ff @(posedge clk) begin
      if (sys_rst || !en) begin
         acc_r <= PHASE_MOD - 32'h1;
      end else if (rise) begin
         acc_r <= sum - PHASE_MOD;
      end else begin
         acc_r <= sum;
      end
   end
endmodule

// >>> design/ptp_top.sv
`timescale 1ns/1ns
module ptp_top #(
   parameter int unsigned MS_CYCLES = ptp_pkg::MS_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output ptp_pkg::ptp_pins_t pins
);
   import ptp_pkg::*;

   // Clamp a speed into the selected band
   function automatic logic [16:0] clamp_f(input logic [31:0] f, input logic [1:0] rng);
      logic [16:0] lo;
      logic [16:0] hi;
      lo = (rng == 2'd0) ? R0_MIN : ((rng == 2'd1) ? R1_MIN : R2_MIN);
      hi = (rng == 2'd0) ? R0_MAX : R12_MAX;
      if (f < {15'h0, lo}) begin
         return lo;
      end else if (f > {15'h0, hi}) begin
         return hi;
      end
      return f[16:0];
   endfunction

   // Magnitude of a signed 33-bit value
   function automatic logic [31:0] mag(input logic [32:0] v);
      logic [32:0] n;
      n = v[32] ? (33'h0 - v) : v;
      return n[31:0];
   endfunction

   // True when the address falls inside a window
   function automatic logic in_win(input logic [11:0] a, input logic [11:0] base,
                                   input logic [11:0] span);
      return (a >= base) && (a < base + span);
   endfunction

   logic [31:0] tbl_r [NCH][TBL_WORDS];
   logic [31:0] elapsed_r [NCH];
   logic [31:0] target_r [NCH];
   logic [31:0] mon_r [NCH];
   logic [3:0] image_r;
   logic [31:0] rd_mux;
   logic rd_err;
   logic wr_go;
   logic rd_go;
   logic [1:0] area_ch;
   logic [1:0] area_word;
   logic [1:0] tbl_ch;
   logic [2:0] tbl_word;
   logic [11:0] area_off;
   logic [11:0] tbl_off;
   logic busy_w [NCH];
   logic [3:0] busy_vec;
   logic ms_tick;
   logic [16:0] ms_cnt_r;
   logic fwd_r [NCH];
   logic rev_r [NCH];

   // Write commits on the edge where pready is seen high
   assign wr_go = psel && penable && pwrite && pready;
   assign rd_go = psel && penable && !pready;
   assign area_off = paddr - OFF_AREA;
   assign tbl_off = paddr - OFF_TBL;
   assign area_ch = area_off[5:4];
   assign area_word = area_off[3:2];
   assign tbl_ch = tbl_off[6:5];
   assign tbl_word = tbl_off[4:2];

   // APB handshake: one wait state per access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= rd_go;
      end
   end

   // Read data and error captured in the wait state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (rd_go) begin
         prdata <= pwrite ? prdata : rd_mux;
         pslverr <= rd_err;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

   // Register read decode
   always_comb begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         rd_err = 1'b1;
      end else if (paddr == OFF_CTRL || paddr == OFF_START) begin
         rd_mux = 32'h0;
      end else if (paddr == OFF_BUSY) begin
         rd_mux = {28'h0, busy_vec};
      end else if (paddr == OFF_IMAGE) begin
         rd_mux = {28'h0, image_r};
      end else if (in_win(paddr, OFF_MON, 12'(NCH * 4))) begin
         rd_mux = mon_r[paddr[3:2]];
      end else if (in_win(paddr, OFF_AREA, 12'(NCH) * AREA_STRIDE)) begin
         case (area_word)
            AW_ELAP_LO: rd_mux = {16'h0, elapsed_r[area_ch][15:0]};
            AW_ELAP_HI: rd_mux = {16'h0, elapsed_r[area_ch][31:16]};
            AW_TGT_LO: rd_mux = {16'h0, target_r[area_ch][15:0]};
            AW_TGT_HI: rd_mux = {16'h0, target_r[area_ch][31:16]};
            default: rd_mux = 32'h0;
         endcase
      end else if (in_win(paddr, OFF_TBL, 12'(NCH) * TBL_STRIDE) &&
                   tbl_word < 3'(TBL_WORDS)) begin
         rd_mux = tbl_r[tbl_ch][tbl_word];
      end else begin
         rd_err = 1'b1;
      end
   end

   // Control write: stored per channel, held until rewritten
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCH; i++) begin
            mon_r[i] <= 32'h0;
         end
      end else if (wr_go && paddr == OFF_CTRL) begin
         mon_r[pwdata[CTRL_CH_LSB +: 2]] <= {24'h0, pwdata[7:0]};
      end
   end

   // Software image of the output pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         image_r <= 4'h0;
      end else if (wr_go && paddr == OFF_IMAGE) begin
         image_r <= pwdata[3:0];
      end
   end

   // Positioning parameter tables
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCH; i++) begin
            for (int j = 0; j < TBL_WORDS; j++) begin
               tbl_r[i][j] <= 32'h0;
            end
         end
      end else if (wr_go && in_win(paddr, OFF_TBL, 12'(NCH) * TBL_STRIDE) &&
                   tbl_word < 3'(TBL_WORDS)) begin
         tbl_r[tbl_ch][tbl_word] <= pwdata;
      end
   end

   // Shared millisecond tick for ramp dwell
   always_ff @(posedge clk) begin
      if (sys_rst || ms_tick) begin
         ms_cnt_r <= 17'h0;
      end else begin
         ms_cnt_r <= ms_cnt_r + 17'h1;
      end
   end
   assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      ptp_state_t st_r;
      ptp_phase_t ph_r;
      logic [31:0] code_r;
      logic [16:0] f0_r;
      logic [16:0] fmax_r;
      logic [16:0] f0_c;
      logic [16:0] fmax_c;
      logic [16:0] cur_r;
      logic [16:0] dlt_r;
      logic [15:0] dwell_r;
      logic [15:0] dcnt_r;
      logic [6:0] step_r;
      logic [6:0] nsteps;
      logic [31:0] rem_r;
      logic [31:0] up_r;
      logic dir_r;
      logic start_c;
      logic stop_c;
      logic [32:0] diff;
      logic [31:0] ramp_ms;
      logic [31:0] q_t;
      logic [31:0] q_f;
      logic nz_t;
      logic done_t;
      logic done_f;
      logic lvl;
      logic rise;
      logic step_ev;
      logic [17:0] inc;
      logic [3:0] omode;
      logic [3:0] oscheme;
      logic [31:0] tb_code;

      assign tb_code = tbl_r[c][TB_CODE];
      assign f0_c = clamp_f(tbl_r[c][TB_F0], tb_code[CC_RANGE_LSB +: 2]);
      assign fmax_c = clamp_f(tbl_r[c][TB_FMAX], tb_code[CC_RANGE_LSB +: 2]);
      assign nsteps = tb_code[CC_STEP_LSB] ? STEPS_60 : STEPS_30;
      assign ramp_ms = (tbl_r[c][TB_RAMP] < {25'h0, nsteps}) ? {25'h0, nsteps}
                       : tbl_r[c][TB_RAMP];
      assign stop_c = mon_r[c][CB_STOP];
      assign start_c = wr_go && paddr == OFF_START && pwdata[1:0] == 2'(c) &&
                       st_r == ST_IDLE && !stop_c;
      assign diff = {tbl_r[c][TB_TARGET][31], tbl_r[c][TB_TARGET]} -
                    {elapsed_r[c][31], elapsed_r[c]};
      assign omode = code_r[7:4];
      assign oscheme = code_r[3:0];
      assign busy_w[c] = (st_r != ST_IDLE);
      assign busy_vec[c] = busy_w[c];
      assign step_ev = ms_tick && (dcnt_r == dwell_r - 16'h1);
      // 1 Hz in band 0 stands for 1.5 Hz
      assign inc = (code_r[CC_RANGE_LSB +: 2] == 2'd0 && cur_r == R0_MIN) ? INC_1P5HZ
                   : {cur_r, 1'b0};

      ptp_div u_div_t (
         .clk(clk),
         .sys_rst(sys_rst),
         .start(start_c),
         .num(ramp_ms),
         .den(nsteps),
         .quot(q_t),
         .rem_nz(nz_t),
         .done(done_t)
      );

      ptp_div u_div_f (
         .clk(clk),
         .sys_rst(sys_rst),
         .start(start_c),
         .num((fmax_c > f0_c) ? {15'h0, fmax_c - f0_c} : 32'h0), // Flat if fmax below f0
         .den(nsteps),
         .quot(q_f),
         .rem_nz(),
         .done(done_f)
      );

      ptp_rate u_rate (
         .clk(clk),
         .sys_rst(sys_rst),
         .en(st_r == ST_RUN && (rem_r != 32'h0 || lvl)),
         .inc(inc),
         .quarter(code_r[CC_DUTY_LSB]),
         .level(lvl),
         .rise(rise)
      );

      // Channel sequencer: load, ramp up, cruise, ramp down
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            st_r <= ST_IDLE;
            ph_r <= PH_ACCEL;
            code_r <= 32'h0;
            f0_r <= R0_MIN;
            fmax_r <= R0_MIN;
            cur_r <= R0_MIN;
            dlt_r <= 17'h0;
            dwell_r <= 16'h1;
            dcnt_r <= 16'h0;
            step_r <= 7'h0;
            rem_r <= 32'h0;
            up_r <= 32'h0;
            dir_r <= 1'b0;
            target_r[c] <= 32'h0;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  if (start_c) begin
                     st_r <= ST_CALC;
                     code_r <= tb_code;
                     f0_r <= f0_c;
                     fmax_r <= (fmax_c > f0_c) ? fmax_c : f0_c;
                     cur_r <= f0_c;
                     ph_r <= PH_ACCEL;
                     step_r <= 7'h0;
                     dcnt_r <= 16'h0;
                     up_r <= 32'h0;
                     if (tb_code[7:4] == MODE_ABS) begin
                        dir_r <= diff[32];
                        rem_r <= mag(diff);
                        target_r[c] <= tbl_r[c][TB_TARGET];
                     end else begin
                        dir_r <= tbl_r[c][TB_TARGET][31];
                        rem_r <= mag({tbl_r[c][TB_TARGET][31], tbl_r[c][TB_TARGET]});
                        target_r[c] <= elapsed_r[c] + tbl_r[c][TB_TARGET];
                     end
                  end
               end
               ST_CALC: begin
                  if (stop_c) begin
                     st_r <= ST_IDLE;
                  end else if (done_t && done_f) begin
                     st_r <= ST_RUN;
                     dwell_r <= 16'(q_t + {31'h0, nz_t});
                     dlt_r <= q_f[16:0];
                  end
               end
               ST_RUN: begin
                  if (stop_c || (rem_r == 32'h0 && !lvl)) begin
                     st_r <= ST_IDLE;
                  end
                  if (rise) begin
                     rem_r <= rem_r - 32'h1;
                     if (ph_r == PH_ACCEL) begin
                        up_r <= up_r + 32'h1;
                     end
                  end
                  if (ph_r != PH_DECEL && rem_r <= up_r) begin
                     ph_r <= PH_DECEL;
                     dcnt_r <= 16'h0;
                  end else if (ms_tick) begin
                     dcnt_r <= step_ev ? 16'h0 : dcnt_r + 16'h1;
                     if (step_ev && ph_r == PH_ACCEL) begin
                        step_r <= step_r + 7'h1;
                        if (step_r + 7'h1 == nsteps) begin
                           ph_r <= PH_CRUISE;
                           cur_r <= fmax_r;
                        end else begin
                           cur_r <= cur_r + dlt_r;
                        end
                     end else if (step_ev && ph_r == PH_DECEL) begin
                        cur_r <= (cur_r > f0_r + dlt_r) ? cur_r - dlt_r : f0_r;
                     end
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end

      // Elapsed count: cleared, loaded or stepped by pulses
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            elapsed_r[c] <= 32'h0;
         end else if (mon_r[c][CB_RESET] ||
                      (wr_go && paddr == OFF_CTRL && pwdata[CTRL_CH_LSB +: 2] == 2'(c) &&
                       pwdata[CB_RESET])) begin
            elapsed_r[c] <= 32'h0;
         end else if (wr_go && in_win(paddr, OFF_AREA, 12'(NCH) * AREA_STRIDE) &&
                      area_ch == 2'(c) && area_word == AW_ELAP_LO) begin
            elapsed_r[c] <= pwdata;
         end else if (rise) begin
            elapsed_r[c] <= dir_r ? elapsed_r[c] - 32'h1 : elapsed_r[c] + 32'h1;
         end
      end

      // Pin drive: pulses in ST_RUN, image bit on fwd and rev low otherwise
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            fwd_r[c] <= 1'b0;
            rev_r[c] <= 1'b0;
         end else if (st_r != ST_RUN) begin
            fwd_r[c] <= (c == 0) ? image_r[0] : ((c == 1) ? image_r[1] :
                        ((c == 2) ? image_r[2] : image_r[3]));
            rev_r[c] <= 1'b0;
         end else if (oscheme == OUT_DIR_FWD_OFF || oscheme == OUT_DIR_FWD_ON) begin
            fwd_r[c] <= lvl;
            rev_r[c] <= (oscheme == OUT_DIR_FWD_OFF) ? dir_r : !dir_r;
         end else begin
            fwd_r[c] <= lvl && !dir_r;
            rev_r[c] <= lvl && dir_r;
         end
      end

      assign pins.fwd[c] = fwd_r[c];
      assign pins.rev[c] = rev_r[c];
      assign pins.near_home[c] = mon_r[c][CB_NEAR];
   end
endmodule

// >>> verif/ptp_drv_model.sv
`timescale 1ns/1ns
module ptp_drv_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic [1:0] sel,
   input wire ptp_pkg::ptp_pins_t pins,
   output logic [31:0] nf,
   output logic [31:0] nr,
   output logic [31:0] hw,
   output logic [31:0] per
);
   import ptp_pkg::*;
   logic f_d = 1'b0;
   logic r_d = 1'b0;
   logic [31:0] hc = 32'h0;
   logic [31:0] pc = 32'h0;
   // Driver counts rising edges on both inputs of the watched channel
   always_ff @(posedge clk) begin
      f_d <= pins.fwd[sel];
      r_d <= pins.rev[sel];
      if (sys_rst || clr) begin
         nf <= 32'h0;
         nr <= 32'h0;
      end else begin
         if (pins.fwd[sel] && !f_d) nf <= nf + 32'h1;
         if (pins.rev[sel] && !r_d) nr <= nr + 32'h1;
      end
   end
   // High time and period of the pulse train
   always_ff @(posedge clk) begin
      pc <= (pins.fwd[sel] && !f_d) ? 32'h1 : pc + 32'h1;
      hc <= pins.fwd[sel] ? hc + 32'h1 : 32'h0;
      if (pins.fwd[sel] && !f_d) per <= pc;
      if (!pins.fwd[sel] && f_d) hw <= hc;
   end
endmodule

// >>> verif/ptp_top_assertions.sv
`timescale 1ns/1ns
module ptp_chk #(
   parameter int unsigned MS_CYCLES = ptp_pkg::MS_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ptp_pkg::ptp_pins_t pins
);
   import ptp_pkg::*;
   logic ctrl_wr;
   // Committed write to the control register
   assign ctrl_wr = psel && penable && pready && pwrite && !pslverr && paddr == OFF_CTRL;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Bus answer timing
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access edge");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("pready without access");
   a_unaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   // Near-home level follows the control write
   a_near_set: assert property (ctrl_wr |=>
      pins.near_home[$past(pwdata[CTRL_CH_LSB +: 2])] == $past(pwdata[CB_NEAR]))
      else $error("near-home not taken from control bit");
   a_near_hold: assert property ($changed(pins.near_home)
      |-> $past(ctrl_wr) || $past(sys_rst))
      else $error("near-home changed without control write");
   a_rdata_hold: assert property ($changed(prdata)
      |-> $past(psel && penable && !pwrite && !pready) || $past(sys_rst))
      else $error("read data changed outside read capture");
endmodule
bind ptp_top ptp_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pins(pins));

// >>> verif/test_pulse_train_positioner.sv
`timescale 1ns/1ns
module test_pulse_train_positioner;
   import ptp_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, nf, nr, hw, per, q;
   logic pready, pslverr, e;
   ptp_pins_t pins;
   logic clr = 1'b0;
   logic [1:0] sel = 2'h0;
   int n_errors = 0;
   int num_checks = 0;
   // Clock, 10 ns period
   always #5 clk = ~clk;
   ptp_top #(.MS_CYCLES(20)) u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins));
   ptp_drv_model u_drv (.clk(clk), .sys_rst(sys_rst), .clr(clr), .sel(sel), .pins(pins),
      .nf(nf), .nr(nr), .hw(hw), .per(per));
   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chkrd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, q);
   endtask
   // Load a table, start, wait for idle, judge pulses and position
   task automatic move(input int ch, input logic [31:0] code, f, tgt, ef, er, el);
      logic [11:0] b;
      int n;
      b = OFF_TBL + 12'(ch) * TBL_STRIDE;
      sel <= 2'(ch);
      clr <= 1'b1;
      wr(b, code);
      wr(b + 12'h004, f);
      wr(b + 12'h008, f);
      wr(b + 12'h00C, 32'd60);
      wr(b + 12'h010, tgt);
      wr(b + 12'h014, 32'h0);
      clr <= 1'b0;
      wr(OFF_START, 32'(ch));
      chkrd("busy_run", OFF_BUSY, 32'h1 << ch);
      chkrd("image_run", OFF_IMAGE, 32'h0);
      n = 0;
      do begin
         apb(1'b0, OFF_BUSY, 32'h0);
         n++;
      end while (q[ch] !== 1'b0 && n < 8000);
      if (n >= 8000) begin
         n_errors++;
         stop_test();
      end
      chk("fwd_count", ef, nf);
      chk("rev_count", er, nr);
      b = OFF_AREA + 12'(ch) * AREA_STRIDE;
      chkrd("elap_lo", b, {16'h0, el[15:0]});
      chkrd("elap_hi", b + 12'h004, {16'h0, el[31:16]});
   endtask
   task automatic t_regs();
      chkrd("busy_rst", OFF_BUSY, 32'h0);
      chkrd("mon_rst", OFF_MON, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      apb(1'b0, 12'h00A, 32'h0);
      chk("unaligned_err", 32'h1, {31'h0, e});
      wr(OFF_BUSY, 32'hF);
      chkrd("busy_ro", OFF_BUSY, 32'h0);
   endtask
   task automatic t_ctrl();
      for (int c = 0; c < 4; c++) begin
         wr(OFF_CTRL, (32'(c) << 8) | 32'h10);
         chkrd("mon_near", OFF_MON + 12'(c) * 12'h004, 32'h10);
      end
      wr(OFF_AREA, 32'h0);
      chk("near_hold", 32'hF, {28'h0, pins.near_home});
      for (int c = 0; c < 4; c++) begin
         wr(OFF_CTRL, 32'(c) << 8);
         chkrd("mon_zero", OFF_MON + 12'(c) * 12'h004, 32'h0);
      end
      chk("near_off", 32'h0, {28'h0, pins.near_home});
   endtask
   task automatic t_elap();
      wr(OFF_AREA + AREA_STRIDE, 32'h0ABC_1234);
      chkrd("elap_lo", OFF_AREA + AREA_STRIDE, 32'h1234);
      chkrd("elap_hi", OFF_AREA + AREA_STRIDE + 12'h004, 32'h0ABC);
      wr(OFF_CTRL, 32'h101);
      chkrd("elap_clr", OFF_AREA + AREA_STRIDE, 32'h0);
      wr(OFF_CTRL, 32'h100);
   endtask
   // Start speeds stay at or below 25 kHz, 20 kHz on channel 2 and 9.8 kHz on channel 3
   task automatic t_moves();
      move(0, 32'h0000_0100, 32'd25000, 32'd3, 32'd3, 32'd0, 32'd3);
      chk("period", 32'h1, {31'h0, per > 3960 && per < 4040});
      chk("half_duty", 32'h1, {31'h0, hw > 1980 && hw < 2020});
      move(0, 32'h0000_0110, 32'd25000, 32'd1, 32'd0, 32'd2, 32'd1);
      chkrd("target", OFF_AREA + 12'h008, 32'h1);
      move(2, 32'h0000_1102, 32'd20000, 32'hFFFF_FFFE, 32'd2, 32'd1, 32'hFFFF_FFFE);
      chk("qtr_duty", 32'h1, {31'h0, hw * 4 > per - 80 && hw * 4 < per + 80});
      move(1, 32'h0001_0113, 32'd25000, 32'd2, 32'd2, 32'd1, 32'd2);
      move(3, 32'h0000_0000, 32'd9800, 32'd2, 32'd2, 32'd0, 32'd2);
      chk("band0_period", 32'h1, {31'h0, per > 10150 && per < 10260});
   endtask
   task automatic t_stop();
      wr(OFF_TBL + 12'h060, 32'h0000_0100);
      wr(OFF_TBL + 12'h064, 32'd20000);
      wr(OFF_TBL + 12'h068, 32'd20000);
      wr(OFF_TBL + 12'h06C, 32'd60);
      wr(OFF_TBL + 12'h070, 32'd1000);
      wr(OFF_START, 32'h3);
      chkrd("busy_on", OFF_BUSY, 32'h8);
      wr(OFF_CTRL, 32'h308);
      chkrd("busy_stop", OFF_BUSY, 32'h0);
      wr(OFF_START, 32'h3);
      chkrd("busy_blocked", OFF_BUSY, 32'h0);
      chkrd("mon_stop", OFF_MON + 12'h00C, 32'h08);
      // Position is untrusted from here; a home return would follow
      wr(OFF_CTRL, 32'h300);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_ctrl();
      t_elap();
      t_moves();
      t_stop();
      stop_test();
   end
endmodule
